// ===== bench/dsbp_ctrl_model.sv
// Behavioural memory controller that drives the port and gathers read words.
`timescale 1ns/1ps
`default_nettype none
module dsbp_ctrl_model (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic out_clk,
   input wire dsbp_pkg::dsbp_word_t rd_data,
   input wire logic rd_data_oe,
   output logic load_strobe_n,
   output logic read_select,
   output dsbp_pkg::dsbp_addr_t addr,
   output dsbp_pkg::dsbp_word_t wr_data,
   output dsbp_pkg::dsbp_mask_t write_mask_n
);
   logic next_true;
   dsbp_pkg::dsbp_word_t rq[$];
   initial begin
      load_strobe_n = 1'h1;
      read_select = 1'h0;
      addr = '0;
      wr_data = '0;
      write_mask_n = 2'h3;
   end
   // The first edge after reset is a true edge; edges then alternate.
   always @(posedge mclk) begin
      next_true <= !rstn ? 1'b1 : !next_true;
   end
   always @(posedge out_clk) begin
      if (rd_data_oe) begin
         rq.push_back(rd_data);
      end
   end
   // Setting comp places the command on a complementary edge, which the device must ignore.
   task automatic cmd(input logic rd, input dsbp_pkg::dsbp_addr_t a,
                      input dsbp_pkg::dsbp_word_t d0, input dsbp_pkg::dsbp_word_t d1,
                      input dsbp_pkg::dsbp_mask_t m0, input dsbp_pkg::dsbp_mask_t m1,
                      input logic comp);
      @(negedge mclk);
      while (next_true != comp) begin
         @(negedge mclk);
      end
      @(posedge mclk);
      load_strobe_n <= 1'h0;
      read_select <= rd;
      addr <= a;
      wr_data <= d0;
      write_mask_n <= m0;
      @(posedge mclk);
      load_strobe_n <= 1'h1;
      addr <= ~a;
      wr_data <= d1;
      write_mask_n <= m1;
      @(posedge mclk);
      // Released lines show the inverse so a late sample cannot pass by luck.
      wr_data <= ~d1;
      write_mask_n <= ~m1;
   endtask
endmodule // dsbp_ctrl_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking testbench of the burst-two SRAM port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   logic mclk, rstn, out_clk, pll_bypass_select, load_strobe_n, read_select;
   logic rd_data_oe, echo_strobe, echo_strobe_n, e;
   dsbp_pkg::dsbp_addr_t addr;
   dsbp_pkg::dsbp_word_t wr_data, rd_data;
   dsbp_pkg::dsbp_mask_t write_mask_n;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Launch clock runs at its own rate with an offset phase.
   initial begin
      out_clk = 1'b0;
      #7;
      forever #24 out_clk = ~out_clk;
   end
   dsbp_core DUT (.mclk(mclk), .rstn(rstn), .out_clk(out_clk), .load_strobe_n(load_strobe_n),
      .read_select(read_select), .addr(addr), .wr_data(wr_data), .write_mask_n(write_mask_n),
      .pll_bypass_select(pll_bypass_select), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
      .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));
   dsbp_ctrl_model M (.mclk(mclk), .rstn(rstn), .out_clk(out_clk), .rd_data(rd_data),
      .rd_data_oe(rd_data_oe), .load_strobe_n(load_strobe_n), .read_select(read_select),
      .addr(addr), .wr_data(wr_data), .write_mask_n(write_mask_n));
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // The ceiling is more than twenty times the length of the whole sequence.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic wr(input dsbp_pkg::dsbp_addr_t a, input dsbp_pkg::dsbp_word_t d0,
                     input dsbp_pkg::dsbp_word_t d1, input dsbp_pkg::dsbp_mask_t m0,
                     input dsbp_pkg::dsbp_mask_t m1, input logic comp);
      M.cmd(1'b0, a, d0, d1, m0, m1, comp);
   endtask
   // Reads one entry and expects exactly two words, in burst order.
   task automatic rd(input dsbp_pkg::dsbp_addr_t a, input dsbp_pkg::dsbp_word_t e0,
                     input dsbp_pkg::dsbp_word_t e1);
      M.rq.delete();
      M.cmd(1'b1, a, '0, '0, 2'h3, 2'h3, 1'b0);
      for (int i = 0; i < 40 && M.rq.size() < 2; i++) begin
         @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
      `CHK("burst size", 2, M.rq.size())
      `CHK("word0", e0, M.rq[0])
      `CHK("word1", e1, M.rq[1])
      `CHK("oe idle", 1'b0, rd_data_oe)
   endtask
   task automatic t_idle();
      `CHK("oe reset", 1'b0, rd_data_oe)
      `CHK("q reset", 18'h0_0000, rd_data)
      // Release of reset needs two launch edges to cross before the echo runs.
      repeat (4) @(posedge out_clk);
      #1 e = echo_strobe;
      `CHK("echo pair", ~e, echo_strobe_n)
      @(posedge out_clk);
      #1;
      `CHK("echo toggle", ~e, echo_strobe)
      $display("done t_idle");
   endtask
   task automatic t_basic();
      wr(19'h0_0005, 18'h1_2345, 18'h2_abcd, 2'h0, 2'h0, 1'b0);
      rd(19'h0_0005, 18'h1_2345, 18'h2_abcd);
      wr(19'h7_ffff, 18'h3_ffff, 18'h0_0001, 2'h0, 2'h0, 1'b0);
      rd(19'h7_ffff, 18'h3_ffff, 18'h0_0001);
      rd(19'h0_0005, 18'h1_2345, 18'h2_abcd);
      $display("done t_basic");
   endtask
   task automatic t_mask();
      wr(19'h0_0100, 18'h0_0000, 18'h0_0000, 2'h0, 2'h0, 1'b0);
      wr(19'h0_0100, 18'h3_ffff, 18'h3_ffff, 2'h1, 2'h2, 1'b0);
      rd(19'h0_0100, 18'h3_fe00, 18'h0_01ff);
      $display("done t_mask");
   endtask
   task automatic t_comp();
      wr(19'h0_0005, 18'h0_1111, 18'h0_2222, 2'h0, 2'h0, 1'b1);
      rd(19'h0_0005, 18'h1_2345, 18'h2_abcd);
      $display("done t_comp");
   endtask
   task automatic t_pll();
      @(posedge mclk);
      pll_bypass_select <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(19'h2_0a0a, 18'h2_aaaa, 18'h1_5555, 2'h0, 2'h0, 1'b0);
      rd(19'h2_0a0a, 18'h2_aaaa, 18'h1_5555);
      $display("done t_pll");
   endtask
   initial begin
      rstn = 1'b0;
      pll_bypass_select = 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_idle();
      t_basic();
      t_mask();
      t_comp();
      t_pll();
      final_report();
   end
endmodule // tb
`default_nettype wire

// ===== core/dsbp_core.sv
// Device side of a separate-I/O double-rate SRAM port with two-word bursts.
`timescale 1ns/1ps
`default_nettype none
module dsbp_core (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic out_clk,
   input wire logic load_strobe_n,
   input wire logic read_select,
   input wire dsbp_pkg::dsbp_addr_t addr,
   input wire dsbp_pkg::dsbp_word_t wr_data,
   input wire dsbp_pkg::dsbp_mask_t write_mask_n,
   input wire logic pll_bypass_select,
   output dsbp_pkg::dsbp_word_t rd_data,
   output logic rd_data_oe,
   output logic echo_strobe,
   output logic echo_strobe_n
);
   // Master-domain state. Each mclk edge stands for one rising master edge,
   // alternating between the true and the complementary input.
   typedef struct packed {
      logic phase;
      logic pll_m;
      logic pll_s;
      dsbp_pkg::dsbp_pins_t inr;
      logic inr_ph;
      logic wr_pend;
      dsbp_pkg::dsbp_addr_t waddr;
      dsbp_pkg::dsbp_word_t wd0;
      dsbp_pkg::dsbp_mask_t wm0;
      logic rd_wait;
      logic rd_stage;
      dsbp_pkg::dsbp_burst_t stg;
      dsbp_pkg::dsbp_burst_t hold;
      logic req_tgl;
   } dsbp_mst_t;

   // Launch-domain state on the output clock.
   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic t_m;
      logic t_s;
      logic t_prev;
      dsbp_pkg::dsbp_os_t state;
      dsbp_pkg::dsbp_word_t w1;
      dsbp_pkg::dsbp_word_t q;
      logic q_oe;
      logic echo;
      logic echo_n;
   } dsbp_ost_t;

   dsbp_mst_t m;
   dsbp_mst_t next_m;
   dsbp_ost_t o;
   dsbp_ost_t next_o;

   logic rd_go;
   logic wr_start;
   logic mem_we;
   logic [2*dsbp_pkg::LANES-1:0] mem_lane;
   dsbp_pkg::dsbp_burst_t mem_rdata;
   dsbp_pkg::dsbp_burst_t mem_wdata;
   logic seen;

   dsbp_mem u_mem (
      .mclk(mclk),
      .we(mem_we),
      .waddr(m.waddr),
      .wdata(mem_wdata),
      .wlane(mem_lane),
      .re(rd_go),
      .raddr(m.inr.addr),
      .rdata(mem_rdata)
   );

   // Word order is set by field name, since a bare concatenation would put
   // the second word into the first field of the packed struct.
   always_comb begin
      mem_wdata.w0 = m.wd0;
      mem_wdata.w1 = m.inr.data;
   end

   // Address decode from the registered pins on a true edge only.
   always_comb begin
      rd_go = 1'h0;
      wr_start = 1'h0;
      if (m.inr_ph == dsbp_pkg::PH_TRUE && !m.inr.load_strobe_n) begin
         rd_go = m.inr.read_select;
         wr_start = !m.inr.read_select;
      end
   end

   // Second word arrives on the complementary edge; the commit needs no strobe.
   always_comb begin
      mem_we = m.wr_pend && m.inr_ph == dsbp_pkg::PH_COMP;
      mem_lane = ~{m.inr.write_mask_n, m.wm0};
   end

   always_comb begin
      next_m = m;
      next_m.phase = ~m.phase;
      next_m.pll_m = pll_bypass_select;
      next_m.pll_s = m.pll_m;
      // Pins are registered before any decode looks at them.
      next_m.inr.load_strobe_n = load_strobe_n;
      next_m.inr.read_select = read_select;
      next_m.inr.addr = addr;
      next_m.inr.data = wr_data;
      next_m.inr.write_mask_n = write_mask_n;
      next_m.inr_ph = m.phase;
      if (wr_start) begin
         next_m.wr_pend = 1'h1;
         next_m.waddr = m.inr.addr;
         next_m.wd0 = m.inr.data;
         next_m.wm0 = m.inr.write_mask_n;
      end else if (mem_we) begin
         next_m.wr_pend = 1'h0;
      end
      next_m.rd_wait = rd_go;
      next_m.rd_stage = 1'h0;
      if (m.rd_wait) begin
         if (m.pll_s) begin
            next_m.stg = mem_rdata;
            next_m.rd_stage = 1'h1;
         end else begin
            next_m.hold = mem_rdata;
            next_m.req_tgl = ~m.req_tgl;
         end
      end
      if (m.rd_stage) begin
         next_m.hold = m.stg;
         next_m.req_tgl = ~m.req_tgl;
      end
      if (!rstn) begin
         next_m = '0;
         next_m.phase = dsbp_pkg::PH_TRUE;
         next_m.inr_ph = dsbp_pkg::PH_COMP;
         next_m.inr.load_strobe_n = dsbp_pkg::RST_LD_N;
         next_m.inr.write_mask_n = dsbp_pkg::RST_MASK_N;
         next_m.wm0 = dsbp_pkg::RST_MASK_N;
      end
   end

   always_ff @(posedge mclk) begin
      m <= next_m;
   end

   // The burst words stay in the hold register until the next toggle, so the
   // launch side may read them once the toggle has passed its two flops.
   assign seen = o.t_s != o.t_prev;

   always_comb begin
      next_o = o;
      next_o.rst_m = rstn;
      next_o.rst_s = o.rst_m;
      next_o.t_m = m.req_tgl;
      next_o.t_s = o.t_m;
      next_o.echo = ~o.echo;
      next_o.echo_n = o.echo;
      unique case (o.state)
         dsbp_pkg::DSBP_OS_IDLE: begin
            next_o.q = '0;
            next_o.q_oe = 1'h0;
            if (seen) begin
               next_o.t_prev = o.t_s;
               next_o.q = m.hold.w0;
               next_o.w1 = m.hold.w1;
               next_o.q_oe = 1'h1;
               next_o.state = dsbp_pkg::DSBP_OS_SECOND;
            end
         end
         dsbp_pkg::DSBP_OS_SECOND: begin
            next_o.q = o.w1;
            next_o.q_oe = 1'h1;
            next_o.state = dsbp_pkg::DSBP_OS_IDLE;
         end
      endcase
      if (!o.rst_s) begin
         next_o.t_prev = o.t_s;
         next_o.state = dsbp_pkg::DSBP_OS_IDLE;
         next_o.w1 = '0;
         next_o.q = '0;
         next_o.q_oe = dsbp_pkg::RST_BIT;
         next_o.echo = dsbp_pkg::RST_BIT;
         next_o.echo_n = ~dsbp_pkg::RST_BIT;
      end
   end

   // Without a separate output clock the board ties out_clk to the master
   // clock, so the same registers launch the data from master edges.
   always_ff @(posedge out_clk) begin
      o <= next_o;
   end

   assign rd_data = o.q;
   assign rd_data_oe = o.q_oe;
   assign echo_strobe = o.echo;
   assign echo_strobe_n = o.echo_n;

   // Checks in the master domain.
   sequence s_write_pair;
      mem_we ##0 (m.inr_ph == dsbp_pkg::PH_COMP);
   endsequence

   sequence s_pub_after(int n);
      ##n $changed(m.req_tgl);
   endsequence

   property p_write_commit;
      @(posedge mclk) disable iff (!rstn)
      wr_start |=> s_write_pair ##0 (m.waddr == $past(m.inr.addr));
   endproperty

   write_commit_a: assert property (p_write_commit)
      else $error("write not committed on the complementary edge");

   first_word_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr_start |=> m.wd0 == $past(m.inr.data) && m.wm0 == $past(m.inr.write_mask_n))
      else $error("first write word not taken from the true edge");

   lane_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
      mem_we |-> mem_lane == ~{m.inr.write_mask_n, $past(m.inr.write_mask_n)})
      else $error("lane enables do not follow the masks");

   true_edge_a: assert property (@(posedge mclk) disable iff (!rstn)
      (rd_go || wr_start) |-> m.inr_ph == dsbp_pkg::PH_TRUE && !m.inr.load_strobe_n)
      else $error("address taken on a complementary edge");

   pll_latency_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd_go && m.pll_s && $stable(m.pll_s) |-> ##2 $stable(m.req_tgl) ##1 $changed(m.req_tgl))
      else $error("read latency with pll not 1.5 cycles");

   dll_latency_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd_go && !m.pll_s && $stable(m.pll_s) |-> s_pub_after(2))
      else $error("read latency without pll not one cycle");

   // Checks in the launch domain.
   burst_launch_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      seen && o.state == dsbp_pkg::DSBP_OS_IDLE |=>
      rd_data_oe ##1 (rd_data_oe && rd_data == $past(o.w1)))
      else $error("burst words not launched in order");

   idle_release_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      !seen && o.state == dsbp_pkg::DSBP_OS_IDLE |=> !rd_data_oe)
      else $error("read outputs driven while port idle");

   // The first cycle out of reset has no toggle behind it yet.
   echo_toggle_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      $past(o.rst_s) |-> echo_strobe != echo_strobe_n && $changed(echo_strobe))
      else $error("echo strobes not complementary and running");

   echo_reset_a: assert property (@(posedge out_clk)
      !o.rst_s |=> !echo_strobe && echo_strobe_n)
      else $error("echo strobes not at rest during reset");

   idle_zero_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      !rd_data_oe |-> rd_data == '0)
      else $error("read data not zero while released");

   sequence s_second_word;
      rd_data_oe ##0 (rd_data == $past(o.w1));
   endsequence

   second_word_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      o.state == dsbp_pkg::DSBP_OS_SECOND |=> s_second_word)
      else $error("second burst word not launched");

   // The hold register is only rewritten on the same edge as the next toggle, so it is safe
   // to compare it from the launch side.
   launch_word_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      seen && o.state == dsbp_pkg::DSBP_OS_IDLE |=> rd_data == $past(m.hold.w0))
      else $error("first burst word not taken from the hold register");

   oe_rise_a: assert property (@(posedge out_clk) disable iff (!o.rst_s)
      $rose(rd_data_oe) |-> o.state == dsbp_pkg::DSBP_OS_SECOND)
      else $error("output enable rose outside a burst");

   // More checks in the master domain. The cycle right after reset has no
   // registered pins behind it, so checks on pin history skip it.
   phase_alternate_a: assert property (@(posedge mclk) disable iff (!rstn)
      $past(rstn) |-> m.inr_ph != $past(m.inr_ph))
      else $error("master edges do not alternate");

   pin_register_a: assert property (@(posedge mclk) disable iff (!rstn)
      $past(rstn) |-> m.inr.addr == $past(addr) && m.inr.data == $past(wr_data))
      else $error("pins not registered before use");

   pll_sync_a: assert property (@(posedge mclk) disable iff (!rstn)
      $past(rstn) && $past(rstn, 2) |-> m.pll_s == $past(pll_bypass_select, 2))
      else $error("mode pin not passed through two flops");

   write_source_a: assert property (@(posedge mclk) disable iff (!rstn)
      mem_we |-> $past(wr_start))
      else $error("array write without a decoded write command");

   write_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      mem_we |=> !m.wr_pend)
      else $error("pending write not cleared after commit");

   stage_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
      m.rd_stage |=> m.hold == $past(m.stg))
      else $error("staged read word not moved to the hold register");

   direct_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
      m.rd_wait && !m.pll_s && !m.rd_stage |=> m.hold == $past(mem_rdata))
      else $error("array word not moved to the hold register");

   toggle_source_a: assert property (@(posedge mclk) disable iff (!rstn)
      $changed(m.req_tgl) |-> $past(m.rd_wait) || $past(m.rd_stage))
      else $error("read published without a read in flight");
endmodule // dsbp_core
`default_nettype wire

// ===== core/dsbp_mem.sv
// Array of two-word entries with a lane-masked write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module dsbp_mem (
   input wire logic mclk,
   input wire logic we,
   input wire dsbp_pkg::dsbp_addr_t waddr,
   input wire dsbp_pkg::dsbp_burst_t wdata,
   input wire logic [2*dsbp_pkg::LANES-1:0] wlane,
   input wire logic re,
   input wire dsbp_pkg::dsbp_addr_t raddr,
   output dsbp_pkg::dsbp_burst_t rdata
);
   localparam int EW = 2 * dsbp_pkg::DW;
   localparam int LW = dsbp_pkg::LW;
   logic [EW-1:0] mem [dsbp_pkg::DEPTH];
   logic [EW-1:0] wflat;

   assign wflat = {wdata.w1, wdata.w0};

   // Unselected lanes keep their old contents.
   always_ff @(posedge mclk) begin
      if (we) begin
         for (int i = 0; i < 2 * dsbp_pkg::LANES; i++) begin
            if (wlane[i]) begin
               mem[waddr][i*LW +: LW] <= wflat[i*LW +: LW];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (re) begin
         // The first word lives in the low half, but the first struct field is the top.
         rdata <= dsbp_pkg::dsbp_burst_t'({mem[raddr][0 +: EW/2], mem[raddr][EW/2 +: EW/2]});
      end
   end
endmodule // dsbp_mem
`default_nettype wire

// ===== pkg/dsbp_pkg.sv
// Package with widths, reset values and carriers of the burst-two SRAM port.
package dsbp_pkg;
   // Variant select: 1 gives 1M x 18 words, 0 gives 2M x 8 words.
   localparam bit WIDE = 1'h1;
   localparam int DW = WIDE ? 18 : 8;
   localparam int AW = WIDE ? 19 : 20;
   localparam int LANES = 2;
   localparam int LW = DW / LANES;
   localparam int DEPTH = 2 ** AW;
   // Phase of the master edge: true edge, then complementary edge.
   localparam logic PH_TRUE = 1'h0;
   localparam logic PH_COMP = 1'h1;
   localparam logic RST_BIT = 1'h0;
   localparam logic RST_LD_N = 1'h1;
   localparam logic [LANES-1:0] RST_MASK_N = 2'h3;
   // Extra master edges of read delay with the PLL mode pin high.
   localparam int PLL_EXTRA_EDGES = 1;

   typedef logic [DW-1:0] dsbp_word_t;
   typedef logic [AW-1:0] dsbp_addr_t;
   typedef logic [LANES-1:0] dsbp_mask_t;

   typedef struct packed {
      logic load_strobe_n;
      logic read_select;
      dsbp_addr_t addr;
      dsbp_word_t data;
      dsbp_mask_t write_mask_n;
   } dsbp_pins_t;

   typedef struct packed {
      dsbp_word_t w0;
      dsbp_word_t w1;
   } dsbp_burst_t;

   typedef enum logic [1:0] {
      DSBP_OS_IDLE = 2'h1,
      DSBP_OS_SECOND = 2'h2
   } dsbp_os_t;
endpackage
